// >>> core/ctq_defines.vh
// Purpose: Constants for the CAN transmit request ordering block
// Assumes: APB byte addresses, 32-bit words
// Notes: Header only, definitions
`ifndef CTQ_DEFINES_VH
`define CTQ_DEFINES_VH
`define CTQ_NBUF 8
`define CTQ_NDED 4
`define CTQ_NQ 4
`define CTQ_OFS_CTRL 12'h000
`define CTQ_OFS_STAT 12'h004
`define CTQ_OFS_TXADD 12'h008
`define CTQ_OFS_TXPEND 12'h00c
`define CTQ_OFS_QPUT 12'h010
`define CTQ_OFS_ISTAT 12'h014
`define CTQ_OFS_IMASK 12'h018
`define CTQ_OFS_EVT 12'h01c
`define CTQ_OFS_BUFID 12'h020
`define CTQ_OFS_BUFHDR 12'h024
`define CTQ_CTRL_INIT 0
`define CTQ_CTRL_CCE 1
`define CTQ_CTRL_FIFO 2
`define CTQ_CTRL_RESET 32'h0000_0003
`define CTQ_ACT_IDLE 2'h0
`define CTQ_ACT_RX 2'h2
`define CTQ_ACT_TX 2'h3
`define CTQ_IRQ_RXBUF 0
`define CTQ_IRQ_RXF0 1
`define CTQ_IRQ_RXF1 2
`define CTQ_IRQ_TXDONE 3
`define CTQ_IFS_BITS 3'h3
`define CTQ_EOF_BITS 4'h7
`define CTQ_FRAME_BITS 8'h40
`endif

// >>> core/ctq_hdr_mem.v
// Purpose: Header memory of the transmit buffers (id, format, length)
// Assumes: One write port, one registered read port
// Notes: Read data valid one cycle after address
`timescale 1ns/100ps
module ctq_hdr_mem (
    input wire clk_sys_in,
    input wire wr_en_in,
    input wire [2:0] wr_addr_in,
    input wire [31:0] wr_data_in,
    input wire [2:0] rd_addr_in,
    output reg [31:0] rd_data_out
);
    reg [31:0] mem [0:7];
    always @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule // ctq_hdr_mem

// >>> core/ctq_tx_order.v
// Purpose: Transmit request ordering and interframe timing of a CAN node
// Assumes: APB slave; bit_tick_in is a one-cycle enable per bit time
// Notes: Buffers 0-3 dedicated, 4-7 queue; header word holds id[28:0],
//   bit 29 format, length code in bits 31:30 (short form)
// Behaviour
// - Same-id dedicated buffers go lowest number first
// - Put index picks lowest free queue buffer
// - Queue order follows storing buffer numbers
// - One add-request write requests all set bits; outside FIFO mode, queue bits only of claimed slots
// - FIFO mode drains in entry order
// - Activity state reads 10 while receiving
// - Dominant at third intermission bit starts frame
// - Receive new flags set at last EOF bit
// - Three intermission bits follow last EOF bit
// - Event record holds served buffer identity
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "ctq_defines.vh"
module ctq_tx_order (
    input wire clk_sys_in,
    input wire reset_in,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire bit_tick_in,
    input wire rx_bit_in,
    input wire rx_sof_in,
    input wire rx_eof_in,
    input wire rx_accept_in,
    input wire [1:0] rx_target_in,
    input wire arb_lost_in,
    input wire tx_ack_in,
    output wire [1:0] protocol_activity_state_out,
    output reg [31:0] tx_shift_hdr_out,
    output reg tx_start_out,
    output wire irq_out
);
    localparam S_IDLE = 3'd0;
    localparam S_LOAD = 3'd1;
    localparam S_TX = 3'd2;
    localparam S_RX = 3'd3;
    localparam S_EOF = 3'd4;
    localparam S_IFS = 3'd5;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [2:0] ctrl_ff;
    reg [7:0] pend_ff;
    reg [3:0] qused_ff;
    reg [3:0] istat_ff;
    reg [3:0] imask_ff;
    reg [2:0] sel_ff;
    reg [2:0] bufsel_ff;
    reg [31:0] evt_ff;
    reg [2:0] ifs_cnt_ff;
    reg [7:0] bit_cnt_ff;
    reg [31:0] rdata_ff;
    reg [7:0] order_ff [0:7];
    reg [7:0] seq_ff;
    reg [2:0] rd_addr;
    wire [31:0] mem_rdata;

    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire wr_txadd = wr && paddr == `CTQ_OFS_TXADD;
    wire wr_hdr = wr && paddr == `CTQ_OFS_BUFHDR;
    wire fifo_mode = ctrl_ff[`CTQ_CTRL_FIFO];
    wire running = ~ctrl_ff[`CTQ_CTRL_INIT];
    // Reset word is a full bus word; only the low control bits exist
    wire [31:0] ctrl_rst = `CTQ_CTRL_RESET;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = rdata_ff;
    assign irq_out = |(istat_ff & imask_ff);
    assign protocol_activity_state_out =
        (state_ff == S_TX || state_ff == S_LOAD) ? `CTQ_ACT_TX :
        (state_ff == S_RX || state_ff == S_EOF) ? `CTQ_ACT_RX :
        `CTQ_ACT_IDLE;

    // Lowest free queue slot: a fixed priority scan, not a ring
    reg [2:0] put_idx;
    reg q_full;
    integer k;
    always @* begin
        put_idx = 3'd4;
        q_full = 1'b1;
        for (k = 3; k >= 0; k = k - 1) begin
            if (!qused_ff[k]) begin
                put_idx = 3'd4 + k[2:0];
                q_full = 1'b0;
            end
        end
    end

    // Pick next buffer. Dedicated/queue: lowest pending number wins,
    // so same-id groups leave in buffer order. FIFO mode: oldest entry.
    reg [2:0] pick;
    reg pick_ok;
    reg [7:0] best_seq;
    integer j;
    always @* begin
        pick = 3'd0;
        pick_ok = 1'b0;
        best_seq = 8'hff;
        for (j = 7; j >= 0; j = j - 1) begin
            if (pend_ff[j] && !fifo_mode) begin
                pick = j[2:0];
                pick_ok = 1'b1;
            end
        end
        if (fifo_mode) begin
            for (j = 0; j < 8; j = j + 1) begin
                if (pend_ff[j] && (!pick_ok ||
                    (order_ff[j] - seq_ff) < (best_seq - seq_ff))) begin
                    pick = j[2:0];
                    pick_ok = 1'b1;
                    best_seq = order_ff[j];
                end
            end
        end
    end

    always @* begin
        rd_addr = bufsel_ff;
        if (state_ff == S_IDLE || state_ff == S_IFS) begin
            rd_addr = pick;
        end
    end

    ctq_hdr_mem u_mem (
        .clk_sys_in(clk_sys_in),
        .wr_en_in(wr_hdr),
        .wr_addr_in(bufsel_ff),
        .wr_data_in(pwdata),
        .rd_addr_in(rd_addr),
        .rd_data_out(mem_rdata)
    );

    // Third intermission bit: pending request or dominant bus opens frame
    wire ifs_last = state_ff == S_IFS && ifs_cnt_ff == `CTQ_IFS_BITS - 3'd1;
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (running && pick_ok) begin
                    nxt_state = S_LOAD;
                end else if (running && rx_sof_in) begin
                    nxt_state = S_RX;
                end
            end
            S_LOAD: nxt_state = S_TX;
            S_TX: begin
                if (arb_lost_in) begin
                    nxt_state = S_RX;
                end else if (tx_ack_in) begin
                    nxt_state = S_EOF;
                end
            end
            S_RX: begin
                if (rx_eof_in) begin
                    nxt_state = S_EOF;
                end
            end
            S_EOF: begin
                if (bit_tick_in && bit_cnt_ff == `CTQ_EOF_BITS - 8'd1) begin
                    nxt_state = S_IFS;
                end
            end
            S_IFS: begin
                if (bit_tick_in && ifs_last) begin
                    if (pick_ok) begin
                        nxt_state = S_LOAD;
                    end else if (!rx_bit_in) begin
                        nxt_state = S_RX;
                    end else begin
                        nxt_state = S_IDLE;
                    end
                end
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    reg tx_was_ff;
    integer n;
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff <= S_IDLE;
            ctrl_ff <= ctrl_rst[2:0];
            pend_ff <= 8'h00;
            qused_ff <= 4'h0;
            istat_ff <= 4'h0;
            imask_ff <= 4'h0;
            sel_ff <= 3'd0;
            bufsel_ff <= 3'd0;
            evt_ff <= 32'h0000_0000;
            ifs_cnt_ff <= 3'd0;
            bit_cnt_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
            seq_ff <= 8'h00;
            tx_shift_hdr_out <= 32'h0000_0000;
            tx_start_out <= 1'b0;
            tx_was_ff <= 1'b0;
            for (n = 0; n < 8; n = n + 1) begin
                order_ff[n] <= 8'h00;
            end
        end else begin
            state_ff <= nxt_state;
            tx_start_out <= 1'b0;
            if (state_ff == S_EOF || state_ff == S_IFS) begin
                if (bit_tick_in) begin
                    bit_cnt_ff <= bit_cnt_ff + 8'd1;
                end
            end else begin
                bit_cnt_ff <= 8'h00;
            end
            if (nxt_state == S_IFS && state_ff != S_IFS) begin
                ifs_cnt_ff <= 3'd0;
            end else if (state_ff == S_IFS && bit_tick_in) begin
                ifs_cnt_ff <= ifs_cnt_ff + 3'd1;
            end
            // Latch pick at decision; header read is registered
            if (nxt_state == S_LOAD) begin
                sel_ff <= pick;
            end
            if (state_ff == S_LOAD) begin
                tx_shift_hdr_out <= mem_rdata;
                tx_start_out <= 1'b1;
                tx_was_ff <= 1'b1;
            end
            if (state_ff == S_RX && nxt_state != S_RX) begin
                tx_was_ff <= 1'b0;
            end
            // Completion and write-one-clear; set beats clear
            begin : irq_upd
                reg [3:0] set_v;
                reg [3:0] clr_v;
                reg [7:0] pclr;
                reg [7:0] pset;
                set_v = 4'h0;
                clr_v = 4'h0;
                pclr = 8'h00;
                pset = 8'h00;
                if (state_ff == S_EOF && nxt_state == S_IFS) begin
                    if (!tx_was_ff && rx_accept_in) begin
                        set_v[rx_target_in] = 1'b1;
                    end
                    if (tx_was_ff) begin
                        set_v[`CTQ_IRQ_TXDONE] = 1'b1;
                        pclr[sel_ff] = 1'b1;
                        evt_ff <= {21'h00_0000, sel_ff,
                            tx_shift_hdr_out[7:0]};
                    end
                end
                if (wr && paddr == `CTQ_OFS_ISTAT) begin
                    clr_v = pwdata[3:0];
                end
                istat_ff <= (istat_ff & ~clr_v) | set_v;
                if (wr_txadd) begin
                    pset = pwdata[7:0];
                    if (!fifo_mode) begin
                        pset[7:4] = pset[7:4] & qused_ff;
                    end
                end
                if (wr_hdr && fifo_mode) begin
                    pset[bufsel_ff] = 1'b1;
                end
                pend_ff <= (pend_ff & ~pclr) | pset;
                for (n = 0; n < 8; n = n + 1) begin
                    if (pset[n] && !pend_ff[n]) begin
                        order_ff[n] <= seq_ff;
                    end
                end
                if (|pset) begin
                    seq_ff <= seq_ff + 8'd1;
                end
                if (pclr[sel_ff] && sel_ff[2]) begin
                    qused_ff[sel_ff[1:0]] <= 1'b0;
                end
            end
            if (wr && paddr == `CTQ_OFS_CTRL) begin
                ctrl_ff <= pwdata[2:0];
            end
            if (wr && paddr == `CTQ_OFS_IMASK) begin
                imask_ff <= pwdata[3:0];
            end
            if (wr && paddr == `CTQ_OFS_BUFID) begin
                bufsel_ff <= pwdata[2:0];
            end
            // Header write into a queue slot claims it outside FIFO mode
            if (wr_hdr && bufsel_ff[2] && !fifo_mode) begin
                qused_ff[bufsel_ff[1:0]] <= 1'b1;
            end
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `CTQ_OFS_CTRL: rdata_ff <= {29'h0, ctrl_ff};
                    `CTQ_OFS_STAT: rdata_ff <= {27'h0, state_ff,
                        protocol_activity_state_out};
                    `CTQ_OFS_TXPEND: rdata_ff <= {24'h0, pend_ff};
                    `CTQ_OFS_QPUT: rdata_ff <= {27'h0, q_full,
                        1'b0, put_idx};
                    `CTQ_OFS_ISTAT: rdata_ff <= {28'h0, istat_ff};
                    `CTQ_OFS_IMASK: rdata_ff <= {28'h0, imask_ff};
                    `CTQ_OFS_EVT: rdata_ff <= evt_ff;
                    `CTQ_OFS_BUFID: rdata_ff <= {29'h0, bufsel_ff};
                    default: rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // ctq_tx_order

// >>> tb/ctq_tx_order_props.sv
// Purpose: Port checker for ctq_tx_order
// Assumes: One clock, async high reset
// Notes: Bound at the foot of this file
`timescale 1ns/100ps
module ctq_tx_order_props (
    input wire clk_sys_in,
    input wire reset_in,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire rx_eof_in,
    input wire [1:0] protocol_activity_state_out,
    input wire [31:0] tx_shift_hdr_out,
    input wire tx_start_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    property p_rdy; pready; endproperty
    property p_err; !pslverr; endproperty
    property p_act; protocol_activity_state_out != 2'h1; endproperty
    property p_pulse; tx_start_out |=> !tx_start_out; endproperty
    property p_hdr; $changed(tx_shift_hdr_out) |-> tx_start_out; endproperty
    property p_prd;
        $changed(prdata) |-> $past(psel && !penable && !pwrite);
    endproperty
    property p_txst;
        tx_start_out |-> ##[0:2] protocol_activity_state_out == 2'h3;
    endproperty
    property p_eof; rx_eof_in |=> !tx_start_out [*8]; endproperty
    a_rdy: assert property (p_rdy) else $error("pready low");
    a_err: assert property (p_err) else $error("pslverr high");
    a_act: assert property (p_act) else $error("bad activity");
    a_pulse: assert property (p_pulse) else $error("long start");
    a_hdr: assert property (p_hdr) else $error("header moved");
    a_prd: assert property (p_prd) else $error("prdata moved");
    a_txst: assert property (p_txst) else $error("no tx state");
    a_eof: assert property (p_eof) else $error("start in eof");
    c_start: cover property (tx_start_out);
    c_rx: cover property (protocol_activity_state_out == 2'h2);
    c_eof: cover property (rx_eof_in);
endmodule // ctq_tx_order_props
bind ctq_tx_order ctq_tx_order_props u_ctq_tx_order_props (.clk_sys_in,
    .reset_in, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .rx_eof_in, .protocol_activity_state_out, .tx_shift_hdr_out,
    .tx_start_out);

// >>> tb/ctq_bus_node.sv
// Purpose: Other nodes on the CAN bus, bit level
// Assumes: One bit time is four clocks
// Notes: Never loses arbitration
`timescale 1ns/100ps
module ctq_bus_node (
    input wire clk_sys_in,
    input wire reset_in,
    input wire rx_go_in,
    input wire [1:0] tgt_in,
    input wire tx_start_in,
    output wire bit_tick_out,
    output wire rx_bit_out,
    output reg rx_sof_out,
    output reg rx_eof_out,
    output reg rx_accept_out,
    output reg [1:0] rx_target_out,
    output reg tx_ack_out
);
    reg [1:0] div_ff;
    reg [6:0] cnt_ff;
    reg rx_ff;
    reg tx_ff;
    assign bit_tick_out = (div_ff == 2'h3);
    // Recessive outside frames; toggling body
    assign rx_bit_out = (rx_ff && cnt_ff < 7'h28) ? cnt_ff[0] : 1'b1;
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            {div_ff, cnt_ff, rx_ff, tx_ff} <= 0;
            {rx_sof_out, rx_eof_out, rx_accept_out, tx_ack_out} <= 0;
            rx_target_out <= 2'h0;
        end else begin
            div_ff <= div_ff + 2'h1;
            {rx_sof_out, rx_eof_out, tx_ack_out} <= 0;
            if (rx_go_in && !rx_ff && !tx_ff) begin
                {rx_ff, rx_sof_out, cnt_ff} <= {2'h3, 7'h00};
                rx_target_out <= tgt_in;
            end else if (tx_start_in) begin
                {tx_ff, cnt_ff} <= {1'b1, 7'h00};
            end else if (bit_tick_out && (rx_ff || tx_ff)) begin
                cnt_ff <= cnt_ff + 7'h01;
                if (cnt_ff == 7'h28) begin
                    {rx_eof_out, rx_accept_out} <= {2{rx_ff}};
                    tx_ack_out <= tx_ff;
                end
                // Quiet through EOF and intermission
                if (cnt_ff == 7'h34) begin
                    {rx_ff, tx_ff, rx_accept_out} <= 0;
                end
            end
        end
    end
endmodule // ctq_bus_node

// >>> tb/ctq_tx_order_tb_top.sv
// Purpose: Self-checking bench for ctq_tx_order
// Assumes: pready answers in the access cycle
// Notes: Frames come from ctq_bus_node
`timescale 1ns/100ps
`include "ctq_defines.vh"
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin \
    mismatches++; $display("BAD %s exp %h got %h", n, e, s); end end
module ctq_tx_order_tb_top;
    reg clk_sys_in = 0, reset_in = 1, psel = 0, penable = 0, pwrite = 0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0000_0000, rd;
    reg rx_go = 0;
    reg [1:0] tgt = 2'h0;
    wire [31:0] prdata, hdr_out;
    wire pready, pslverr, tick, rx_bit, sof, eof, acc, ack, start, irq_out;
    wire [1:0] rx_tgt, act;
    int mismatches = 0, comparisons = 0, cycles = 0, acks = 0, k, w;
    int order[5] = '{2, 1, 0, 5, 4};
    int fo[3] = '{3, 1, 2};
    logic [31:0] q[$];
    always #2.5 clk_sys_in = ~clk_sys_in;
    ctq_tx_order u_ctq_tx_order (.clk_sys_in(clk_sys_in),
        .reset_in(reset_in), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bit_tick_in(tick),
        .rx_bit_in(rx_bit), .rx_sof_in(sof), .rx_eof_in(eof),
        .rx_accept_in(acc), .rx_target_in(rx_tgt), .arb_lost_in(1'b0),
        .tx_ack_in(ack), .protocol_activity_state_out(act),
        .tx_shift_hdr_out(hdr_out), .tx_start_out(start),
        .irq_out(irq_out));
    ctq_bus_node u_ctq_bus_node (.clk_sys_in(clk_sys_in),
        .reset_in(reset_in), .rx_go_in(rx_go), .tgt_in(tgt),
        .tx_start_in(start), .bit_tick_out(tick), .rx_bit_out(rx_bit),
        .rx_sof_out(sof), .rx_eof_out(eof), .rx_accept_out(acc),
        .rx_target_out(rx_tgt), .tx_ack_out(ack));
    function [31:0] hdr(input int i);
        // Same id everywhere; length and format bits tell buffers apart
        hdr = {i[1:0], i[2], 29'h0000_0123};
    endfunction
    task summarize;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task xfer(input bit wr, input [11:0] a, input [31:0] d);
        @(posedge clk_sys_in);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
        @(posedge clk_sys_in);
        penable <= 1;
        do @(posedge clk_sys_in); while (pready !== 1'b1);
        rd = prdata;
        {psel, penable} <= 2'h0;
    endtask
    task chk_rd(input [11:0] a, input [31:0] e);
        xfer(0, a, 32'h0000_0000);
        `CHK($sformatf("reg %h", a), e, rd)
    endtask
    task wait_acc(input bit v);
        for (w = 0; acc !== v && w < 1000; w++) @(posedge clk_sys_in);
    endtask
    always @(posedge clk_sys_in) begin
        cycles++;
        if (start) q.push_back(hdr_out);
        if (ack) acks++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys_in);
        reset_in <= 0;
        chk_rd(`CTQ_OFS_CTRL, `CTQ_CTRL_RESET);
        chk_rd(12'h040, 32'h0000_0000);
        chk_rd(`CTQ_OFS_QPUT, 32'h0000_0004);
        for (k = 0; k < 5; k++) begin
            xfer(1, `CTQ_OFS_BUFID, order[k]);
            xfer(1, `CTQ_OFS_BUFHDR, hdr(order[k]));
            if (k == 3) chk_rd(`CTQ_OFS_QPUT, 32'h0000_0004);
        end
        chk_rd(`CTQ_OFS_QPUT, 32'h0000_0006);
        xfer(1, `CTQ_OFS_CTRL, 32'h0000_0001);
        chk_rd(`CTQ_OFS_TXPEND, 32'h0000_0000);
        xfer(1, `CTQ_OFS_TXADD, 32'h0000_0037);
        chk_rd(`CTQ_OFS_TXPEND, 32'h0000_0037);
        xfer(1, `CTQ_OFS_CTRL, 32'h0000_0000);
        for (w = 0; acks < 5 && w < 5000; w++) @(posedge clk_sys_in);
        // Event record lands at end of EOF, well after the ack pulse
        repeat (80) @(posedge clk_sys_in);
        for (k = 0; k < 5; k++) `CHK("order", hdr(k < 3 ? k : k + 1), q[k])
        chk_rd(`CTQ_OFS_EVT, 32'h0000_0523);
        chk_rd(`CTQ_OFS_TXPEND, 32'h0000_0000);
        xfer(1, `CTQ_OFS_ISTAT, 32'h0000_000f);
        xfer(1, `CTQ_OFS_IMASK, 32'h0000_0006);
        for (k = 0; k < 3; k++) begin
            tgt <= k[1:0];
            rx_go <= 1;
            @(posedge clk_sys_in);
            rx_go <= 0;
            repeat (20) @(posedge clk_sys_in);
            `CHK("act", `CTQ_ACT_RX, act)
            wait_acc(1);
            wait_acc(0);
            chk_rd(`CTQ_OFS_ISTAT, 32'h0000_0001 << k);
            `CHK("irq", k != 0, irq_out)
            xfer(1, `CTQ_OFS_ISTAT, 32'h0000_0001 << k);
            @(posedge clk_sys_in);
            `CHK("irq clear", 1'b0, irq_out)
        end
        repeat (12) @(posedge clk_sys_in);
        xfer(1, `CTQ_OFS_CTRL, 32'h0000_0004);
        for (k = 0; k < 3; k++) begin
            xfer(1, `CTQ_OFS_BUFID, fo[k]);
            xfer(1, `CTQ_OFS_BUFHDR, hdr(fo[k]));
        end
        for (w = 0; acks < 8 && w < 5000; w++) @(posedge clk_sys_in);
        repeat (80) @(posedge clk_sys_in);
        for (k = 0; k < 3; k++) `CHK("fifo", hdr(fo[k]), q[5 + k])
        chk_rd(`CTQ_OFS_EVT, 32'h0000_0223);
        xfer(1, `CTQ_OFS_CTRL, 32'h0000_0000);
        xfer(1, `CTQ_OFS_TXADD, 32'h0000_0001);
        xfer(1, `CTQ_OFS_TXADD, 32'h0000_0002);
        chk_rd(`CTQ_OFS_TXPEND, 32'h0000_0003);
        for (w = 0; acks < 10 && w < 5000; w++) @(posedge clk_sys_in);
        repeat (80) @(posedge clk_sys_in);
        for (k = 0; k < 2; k++) `CHK("single", hdr(k), q[8 + k])
        chk_rd(`CTQ_OFS_TXPEND, 32'h0000_0000);
        summarize();
    end
endmodule // ctq_tx_order_tb_top
